// ### common/port_ctrl_defines.vh
/*
 Register offsets, bit positions and timing counts for the root hub
 port enable / suspend control block.
 Assumes inclusion by bare name from an rtl file; definitions only.
*/
`ifndef PORT_CTRL_DEFINES_VH
`define PORT_CTRL_DEFINES_VH

`define PORT_STATE_OFS     12'h054
`define IRQ_STATUS_OFS     12'h0f0
`define IRQ_MASK_OFS       12'h0f4
`define PORT_CFG_OFS       12'h0f8

`define BIT_ATTACHED       0
`define BIT_ENABLED        1
`define BIT_SUSPENDED      2
`define BIT_OVERCURRENT    3
`define BIT_RESET_SIG      4
`define BIT_ATTACH_CHG     16
`define BIT_ENABLE_CHG     17
`define BIT_SUSPEND_CHG    18
`define BIT_OVC_CHG        19
`define BIT_RESET_CHG      20

`define IRQ_WIDTH          5
`define IRQ_MASK_RST       5'h00
`define CFG_PER_PORT_OVC   0
`define CFG_RST            1'h1

`define RESET_TIME_US      10
`define RESUME_TIME_US     20
`define CLK_MHZ            250
`define RESET_CYCLES       (`RESET_TIME_US * `CLK_MHZ)
`define RESUME_CYCLES      (`RESUME_TIME_US * `CLK_MHZ)

`endif

// ### rtl/root_hub_port_enable_suspend_ctrl.v
/*
 Root hub downstream port: attach, enable, suspend, overcurrent and
 reset bits of the port state register, reached over APB, with sticky
 change flags, an interrupt mask and a level interrupt.
 Assumes the port status inputs arrive asynchronously from the port
 logic and that the global resume indication is on core_clk_i.
*/
// Register access over APB is this design's own decision.
`include "port_ctrl_defines.vh"

module root_hub_port_enable_suspend_ctrl #(
  parameter RESET_CYCLES  = `RESET_CYCLES,
  parameter RESUME_CYCLES = `RESUME_CYCLES
) (
  input  wire        core_clk_i,
  input  wire        resetn_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire        attached_i,
  input  wire        overcurrent_i,
  input  wire        port_power_i,
  input  wire        bus_error_i,
  input  wire        remote_resume_i,
  input  wire        global_resume_state_i,
  input  wire        reset_start_i,
  output reg         resume_to_host_o,
  output reg         reset_drive_o,
  output reg         resume_drive_o,
  output reg         irq_o
);

  localparam CW = 20;

  // One-hot port signalling states
  localparam ST_IDLE   = 3'b001;
  localparam ST_RESET  = 3'b010;
  localparam ST_RESUME = 3'b100;

  reg        rst_s1_ff;
  reg        rst_n_ff;
  wire       rst_n = rst_n_ff;

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff  <= rst_s1_ff;
    end
  end

  // Three-stage synchronisers; change accepted when stages 2 and 3 agree
  localparam NSYNC = 5;
  wire [NSYNC-1:0] raw_in = {reset_start_i, remote_resume_i, bus_error_i,
                             port_power_i, overcurrent_i};
  wire [NSYNC-1:0] sync_q;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      reg s1_ff;
      reg s2_ff;
      reg s3_ff;
      reg q_ff;
      always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
          s3_ff <= 1'b0;
          q_ff  <= 1'b0;
        end else begin
          s1_ff <= raw_in[gi];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff)
            q_ff <= s3_ff;
        end
      end
      assign sync_q[gi] = q_ff;
    end
  endgenerate

  // Attach sync separate so it can be read as a plain level
  reg att1_ff;
  reg att2_ff;
  reg att3_ff;
  reg attached_ff;
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      att1_ff     <= 1'b0;
      att2_ff     <= 1'b0;
      att3_ff     <= 1'b0;
      attached_ff <= 1'b0;
    end else begin
      att1_ff <= attached_i;
      att2_ff <= att1_ff;
      att3_ff <= att2_ff;
      if (att2_ff == att3_ff)
        attached_ff <= att3_ff;
    end
  end

  wire ovc_s    = sync_q[0];
  wire power_s  = sync_q[1];
  wire buserr_s = sync_q[2];
  wire rresume_s = sync_q[3];
  wire rstreq_s = sync_q[4];

  function is_write_one;
    input [31:0] data;
    input integer pos;
    begin
      is_write_one = data[pos];
    end
  endfunction

  reg [2:0]    state_ff;
  reg [2:0]    nxt_state;
  reg [CW-1:0] cnt_ff;
  reg [CW-1:0] nxt_cnt;
  reg          enabled_ff;
  reg          nxt_enabled;
  reg          suspended_ff;
  reg          nxt_suspended;
  reg          cfg_ff;
  reg [`IRQ_WIDTH-1:0] status_ff;
  reg [`IRQ_WIDTH-1:0] nxt_status;
  reg [`IRQ_WIDTH-1:0] mask_ff;
  reg          attached_d_ff;
  reg          ovc_d_ff;
  reg          rstreq_d_ff;

  wire access   = psel_i & penable_i & ~pready_o;
  wire wr       = access & pwrite_i;
  wire rd       = access & ~pwrite_i;
  wire wr_port  = wr & (paddr_i == `PORT_STATE_OFS);
  wire rd_stat  = rd & (paddr_i == `IRQ_STATUS_OFS);
  wire mapped   = (paddr_i == `PORT_STATE_OFS) |
                  (paddr_i == `IRQ_STATUS_OFS) |
                  (paddr_i == `IRQ_MASK_OFS) |
                  (paddr_i == `PORT_CFG_OFS);

  wire ovc_bit  = cfg_ff & ovc_s;
  wire detach   = attached_d_ff & ~attached_ff;
  wire hw_dis   = ovc_s | ~attached_ff | ~power_s | buserr_s;
  wire wr_clr_en  = wr_port & is_write_one(pwdata_i, `BIT_ATTACHED);
  wire wr_set_en  = wr_port & is_write_one(pwdata_i, `BIT_ENABLED);
  wire wr_set_sus = wr_port & is_write_one(pwdata_i, `BIT_SUSPENDED);
  wire wr_resume  = wr_port & is_write_one(pwdata_i, `BIT_OVERCURRENT);
  wire cnt_done   = (cnt_ff == {CW{1'b0}});
  wire reset_done  = (state_ff == ST_RESET) & cnt_done;
  wire resume_done = (state_ff == ST_RESUME) & cnt_done;
  wire wr_set_rst  = wr_port & is_write_one(pwdata_i, `BIT_RESET_SIG);

  // Events: 0 attach chg, 1 enable chg, 2 suspend chg, 3 ovc chg, 4 reset chg
  reg [`IRQ_WIDTH-1:0] evt;

  always @* begin
    nxt_state     = state_ff;
    nxt_cnt       = cnt_ff;
    nxt_enabled   = enabled_ff;
    nxt_suspended = suspended_ff;
    evt           = {`IRQ_WIDTH{1'b0}};
    evt[0]        = attached_d_ff ^ attached_ff;
    evt[3]        = cfg_ff & (ovc_d_ff ^ ovc_s);
    case (state_ff)
      ST_IDLE: begin
        if ((wr_set_rst | (rstreq_s & ~rstreq_d_ff)) & attached_ff) begin
          nxt_state = ST_RESET;
          nxt_cnt   = RESET_CYCLES[CW-1:0] - 20'h00001;
        end else if (suspended_ff & (wr_resume | rresume_s)) begin
          nxt_state = ST_RESUME;
          nxt_cnt   = RESUME_CYCLES[CW-1:0] - 20'h00001;
        end
      end
      ST_RESET: begin
        nxt_cnt = cnt_ff - 20'h00001;
        if (cnt_done) begin
          nxt_state     = ST_IDLE;
          evt[4]        = 1'b1;
          nxt_enabled   = 1'b1;
          nxt_suspended = 1'b0;
        end
      end
      ST_RESUME: begin
        nxt_cnt = cnt_ff - 20'h00001;
        if (cnt_done) begin
          nxt_state     = ST_IDLE;
          evt[2]        = 1'b1;
          nxt_enabled   = 1'b1;
          nxt_suspended = 1'b0;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (wr_set_rst & ~attached_ff)
      evt[0] = 1'b1;
    if (wr_set_sus & ~reset_done & ~resume_done) begin
      if (attached_ff)
        nxt_suspended = 1'b1;
      else
        evt[0] = 1'b1;
    end
    if (wr_set_en) begin
      if (attached_ff)
        nxt_enabled = 1'b1;
      else
        evt[0] = 1'b1;
    end
    if (wr_clr_en)
      nxt_enabled = 1'b0;
    if (global_resume_state_i) begin
      nxt_suspended = 1'b0;
      if (state_ff == ST_RESUME)
        nxt_state = ST_IDLE;
    end
    // Hardware disable overrides any enable set in the same cycle
    if (hw_dis & enabled_ff) begin
      nxt_enabled = 1'b0;
      evt[1]      = 1'b1;
    end else if (hw_dis) begin
      nxt_enabled = 1'b0;
    end
    if (detach | ~attached_ff)
      nxt_suspended = 1'b0;
    // Sticky: a new event wins over the read that clears it
    nxt_status = (rd_stat ? {`IRQ_WIDTH{1'b0}} : status_ff) | evt;
  end

  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_ff      <= ST_IDLE;
      cnt_ff        <= {CW{1'b0}};
      enabled_ff    <= 1'b0;
      suspended_ff  <= 1'b0;
      status_ff     <= {`IRQ_WIDTH{1'b0}};
      attached_d_ff <= 1'b0;
      ovc_d_ff      <= 1'b0;
      rstreq_d_ff   <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      cnt_ff        <= nxt_cnt;
      enabled_ff    <= nxt_enabled;
      suspended_ff  <= nxt_suspended;
      status_ff     <= nxt_status;
      attached_d_ff <= attached_ff;
      ovc_d_ff      <= ovc_s;
      rstreq_d_ff   <= rstreq_s;
    end
  end

  // Configuration and mask registers
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff  <= `CFG_RST;
      mask_ff <= `IRQ_MASK_RST;
    end else begin
      if (wr & (paddr_i == `PORT_CFG_OFS))
        cfg_ff <= pwdata_i[`CFG_PER_PORT_OVC];
      if (wr & (paddr_i == `IRQ_MASK_OFS))
        mask_ff <= pwdata_i[`IRQ_WIDTH-1:0];
    end
  end

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (paddr_i)
      `PORT_STATE_OFS: begin
        rd_mux[`BIT_ATTACHED]    = attached_ff;
        rd_mux[`BIT_ENABLED]     = enabled_ff;
        rd_mux[`BIT_SUSPENDED]   = suspended_ff;
        rd_mux[`BIT_OVERCURRENT] = ovc_bit;
        rd_mux[`BIT_RESET_SIG]   = (state_ff == ST_RESET);
        rd_mux[`BIT_ATTACH_CHG]  = status_ff[0];
        rd_mux[`BIT_ENABLE_CHG]  = status_ff[1];
        rd_mux[`BIT_SUSPEND_CHG] = status_ff[2];
        rd_mux[`BIT_OVC_CHG]     = status_ff[3];
        rd_mux[`BIT_RESET_CHG]   = status_ff[4];
      end
      `IRQ_STATUS_OFS: rd_mux[`IRQ_WIDTH-1:0] = status_ff;
      `IRQ_MASK_OFS:   rd_mux[`IRQ_WIDTH-1:0] = mask_ff;
      `PORT_CFG_OFS:   rd_mux[`CFG_PER_PORT_OVC] = cfg_ff;
      default:         rd_mux = 32'h00000000;
    endcase
  end

  // Registered outputs; APB answers one cycle into the access phase
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_o         <= 32'h00000000;
      pready_o         <= 1'b0;
      pslverr_o        <= 1'b0;
      resume_to_host_o <= 1'b0;
      reset_drive_o    <= 1'b0;
      resume_drive_o   <= 1'b0;
      irq_o            <= 1'b0;
    end else begin
      pready_o         <= access;
      pslverr_o        <= access & ~mapped;
      prdata_o         <= rd ? rd_mux : 32'h00000000;
      resume_to_host_o <= suspended_ff & rresume_s;
      reset_drive_o    <= (nxt_state == ST_RESET);
      resume_drive_o   <= (nxt_state == ST_RESUME);
      irq_o            <= |(nxt_status & mask_ff);
    end
  end

endmodule

// ### test/root_hub_port_enable_suspend_ctrl_sva.sv
/*
 Checker for the port control block: APB answer timing, refusal of
 unmapped addresses, reset and resume signalling lengths.
 Assumes it is bound to the top module as below.
*/
`include "port_ctrl_defines.vh"
module port_ctrl_sva #(
  parameter RESET_CYCLES  = 8,
  parameter RESUME_CYCLES = 8
) (
  input wire logic        core_clk_i,
  input wire logic        resetn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        global_resume_state_i,
  input wire logic        resume_to_host_o,
  input wire logic        reset_drive_o,
  input wire logic        resume_drive_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [15:0] run_ff;
  wire         mapped = paddr_i == `PORT_STATE_OFS ||
                        paddr_i == `IRQ_STATUS_OFS ||
                        paddr_i == `IRQ_MASK_OFS || paddr_i == `PORT_CFG_OFS;
  // Length of the current reset or resume run; the two never overlap
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i)
      run_ff <= 16'h0000;
    else
      run_ff <= (reset_drive_o | resume_drive_o) ? run_ff + 16'h0001 : 16'h0;
  end
  ready_answer_a: assert property (psel_i && penable_i && !pready_o
    |=> pready_o)
    else $error("access not answered next cycle");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside answer");
  unmapped_err_a: assert property (pready_o && !mapped |-> pslverr_o)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (pready_o && mapped |-> !pslverr_o)
    else $error("mapped access refused");
  reset_len_a: assert property ($fell(reset_drive_o) |->
    run_ff >= RESET_CYCLES - 1 && run_ff <= RESET_CYCLES + 2)
    else $error("port reset length wrong");
  resume_len_a: assert property ($fell(resume_drive_o) &&
    !$past(global_resume_state_i) |->
    run_ff >= RESUME_CYCLES - 1 && run_ff <= RESUME_CYCLES + 2)
    else $error("resume length wrong");
  cover property ($rose(reset_drive_o));
  cover property ($rose(resume_drive_o));
  cover property (pready_o && pslverr_o);
  cover property ($rose(resume_to_host_o));
endmodule

bind root_hub_port_enable_suspend_ctrl port_ctrl_sva #(
  .RESET_CYCLES(RESET_CYCLES), .RESUME_CYCLES(RESUME_CYCLES)
) port_ctrl_sva_inst (.core_clk_i, .resetn_i, .psel_i, .penable_i, .paddr_i,
  .prdata_o, .pready_o, .pslverr_o, .global_resume_state_i,
  .resume_to_host_o, .reset_drive_o, .resume_drive_o);

// ### test/root_hub_port_enable_suspend_ctrl_test.sv
/*
 Bench for the root hub port control block: reset values, refused
 commands, port reset, suspend and resume, hardware disables.
 Assumes short signalling lengths and the device model beside it.
*/
`include "port_ctrl_defines.vh"
module root_hub_port_enable_suspend_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [11:0] a; logic [31:0] d; logic e;} row_t;
  logic        core_clk_i = 1'h0, resetn_i = 1'h0;
  logic        psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
  logic        port_power_i = 1'h1, bus_error_i = 1'h0;
  logic        global_resume_state_i = 1'h0, reset_start_i = 1'h0;
  logic        plug = 1'h0, fault = 1'h0, wake = 1'h0, e;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, q, x, prdata_o;
  logic        pready_o, pslverr_o, resume_to_host_o, reset_drive_o;
  logic        resume_drive_o, irq_o;
  wire         attached_i, overcurrent_i, remote_resume_i;
  int          num_errors = 0, checks = 0;
  row_t        rows[5] = '{'{`PORT_STATE_OFS, 32'h0, 1'h0},
    '{`IRQ_STATUS_OFS, 32'h0, 1'h0}, '{`IRQ_MASK_OFS, 32'h0, 1'h0},
    '{`PORT_CFG_OFS, 32'h1, 1'h0}, '{12'h100, 32'h0, 1'h1}};

  root_hub_port_enable_suspend_ctrl #(.RESET_CYCLES(8), .RESUME_CYCLES(8))
    root_hub_port_enable_suspend_ctrl_inst (.*);
  usb_port_device usb_port_device_inst (.core_clk_i(core_clk_i),
    .plug_i(plug), .fault_i(fault), .wake_i(wake),
    .reset_drive_i(reset_drive_o), .resume_drive_i(resume_drive_o),
    .attached_o(attached_i), .overcurrent_o(overcurrent_i),
    .remote_resume_o(remote_resume_i));

  initial begin
    forever #2 core_clk_i = ~core_clk_i;
  end

  task automatic chk_word(input logic [31:0] got, exp, msk);
    checks++;
    if ((got & msk) !== (exp & msk)) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, exp);
    chk_word({31'h0, got}, {31'h0, exp}, 32'h1);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'h1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'h1 && n < 40);
    chk_bit(pready_o, 1'h1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, m);
    apb(1'h0, a, 32'h0);
    chk_word(q, x, m);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 60) begin
      @(posedge core_clk_i);
      n++;
    end
    chk_bit(s, v);
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #100us;
    num_errors++;
    stop_test();
  end

  initial begin
    idle(5);
    resetn_i <= 1'h1;
    idle(3);
    foreach (rows[i]) begin
      rd(rows[i].a, rows[i].d, 32'hffffffff);
      chk_bit(e, rows[i].e);
    end
    // Enable, suspend and port reset requests on a detached port
    apb(1'h1, `PORT_STATE_OFS, 32'h16);
    rd(`PORT_STATE_OFS, 32'h10000, 32'h10016);
    chk_bit(irq_o, 1'h0);
    apb(1'h1, `IRQ_MASK_OFS, 32'h1f);
    idle(2);
    chk_bit(irq_o, 1'h1);
    rd(`IRQ_STATUS_OFS, 32'h1, 32'h1);
    idle(2);
    chk_bit(irq_o, 1'h0);
    apb(1'h1, `IRQ_MASK_OFS, 32'h0);
    plug <= 1'h1;
    idle(10);
    rd(`PORT_STATE_OFS, 32'h1, 32'h1f);
    apb(1'h1, `PORT_STATE_OFS, 32'h2);
    rd(`PORT_STATE_OFS, 32'h3, 32'h3);
    apb(1'h1, `PORT_STATE_OFS, 32'h1);
    rd(`PORT_STATE_OFS, 32'h1, 32'h3);
    reset_start_i <= 1'h1;
    wait_for(reset_drive_o, 1'h1);
    rd(`PORT_STATE_OFS, 32'h10, 32'h10);
    reset_start_i <= 1'h0;
    wait_for(reset_drive_o, 1'h0);
    idle(2);
    rd(`PORT_STATE_OFS, 32'h100003, 32'h100017);
    apb(1'h0, `IRQ_STATUS_OFS, 32'h0);
    apb(1'h1, `PORT_STATE_OFS, 32'h8);
    idle(2);
    chk_bit(resume_drive_o, 1'h0);
    apb(1'h1, `PORT_STATE_OFS, 32'h4);
    apb(1'h1, `PORT_STATE_OFS, 32'h0);
    rd(`PORT_STATE_OFS, 32'h4, 32'h4);
    apb(1'h1, `PORT_STATE_OFS, 32'h8);
    wait_for(resume_drive_o, 1'h1);
    rd(`PORT_STATE_OFS, 32'h4, 32'h4);
    wait_for(resume_drive_o, 1'h0);
    idle(2);
    rd(`PORT_STATE_OFS, 32'h40002, 32'h40006);
    apb(1'h1, `PORT_STATE_OFS, 32'h4);
    wake <= 1'h1;
    wait_for(resume_to_host_o, 1'h1);
    wake <= 1'h0;
    global_resume_state_i <= 1'h1;
    idle(4);
    global_resume_state_i <= 1'h0;
    idle(2);
    rd(`PORT_STATE_OFS, 32'h0, 32'h4);
    // Causes in turn: power off, bus error, overcurrent, detach
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, `PORT_STATE_OFS, 32'h2);
      apb(1'h0, `IRQ_STATUS_OFS, 32'h0);
      {plug, fault} <= {i != 3, i == 2};
      {bus_error_i, port_power_i} <= {i == 1, i != 0};
      idle(10);
      x = {28'h0002000, i == 2, 3'h0};
      rd(`PORT_STATE_OFS, x, 32'h2000a);
      {plug, fault, bus_error_i, port_power_i} <= 4'h9;
      idle(10);
    end
    apb(1'h1, `PORT_CFG_OFS, 32'h0);
    fault <= 1'h1;
    idle(10);
    rd(`PORT_STATE_OFS, 32'h0, 32'h8);
    fault <= 1'h0;
    idle(10);
    apb(1'h1, `PORT_STATE_OFS, 32'h2);
    apb(1'h1, `PORT_STATE_OFS, 32'h4);
    resetn_i <= 1'h0;
    idle(3);
    resetn_i <= 1'h1;
    idle(10);
    rd(`PORT_STATE_OFS, 32'h1, 32'hf);
    // Port reset started by a register write on an attached port
    apb(1'h1, `PORT_STATE_OFS, 32'h10);
    rd(`PORT_STATE_OFS, 32'h11, 32'h13);
    wait_for(reset_drive_o, 1'h0);
    idle(2);
    rd(`PORT_STATE_OFS, 32'h100003, 32'h100013);
    stop_test();
  end
endmodule

// ### test/usb_port_device.sv
/*
 Behavioural USB device on the downstream port: attach, overcurrent and
 remote wakeup, steered by the bench. Assumes the bench's clock.
*/
module usb_port_device (
  input  wire logic core_clk_i,
  input  wire logic plug_i,
  input  wire logic fault_i,
  input  wire logic wake_i,
  input  wire logic reset_drive_i,
  input  wire logic resume_drive_i,
  output logic      attached_o = 1'h0,
  output logic      overcurrent_o = 1'h0,
  output logic      remote_resume_o = 1'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge core_clk_i) begin
    attached_o      <= plug_i;
    overcurrent_o   <= fault_i;
    // Wakeup stops once the host answers with resume or reset signalling
    remote_resume_o <= wake_i & plug_i & ~reset_drive_i & ~resume_drive_i;
  end
endmodule
